/* ddrl_pkg.sv */
// ddrl_pkg: constants for the ddr read latency table and its gap sequencer
// assumes: used by ddrl_table and ddrl_gap through explicit package references
`default_nettype none
package ddrl_pkg;
  // -----------------------------------------------------------------
  // table layout
  // -----------------------------------------------------------------
  localparam logic [7:0] ROW_BASE    = 8'h0c; // first row byte offset
  localparam logic [7:0] ROW_LEN     = 8'h08; // bytes per row
  localparam int         NUM_ROWS    = 4;
  localparam logic [7:0] OFS_LAST    = 8'h2b;
  // latency code held per row, in row order
  localparam logic [1:0] CODE_ROW0   = 2'h3;
  localparam logic [1:0] CODE_ROW1   = 2'h0;
  localparam logic [1:0] CODE_ROW2   = 2'h1;
  localparam logic [1:0] CODE_ROW3   = 2'h2;
  // -----------------------------------------------------------------
  // frequency ceilings, MHz encoded directly
  // -----------------------------------------------------------------
  localparam logic [7:0] FREQ_50MHZ  = 8'h32;
  localparam logic [7:0] FREQ_66MHZ  = 8'h42;
  // -----------------------------------------------------------------
  // mode and dummy cycle counts
  // -----------------------------------------------------------------
  localparam logic [7:0] MODE_NONE   = 8'h00;
  localparam logic [7:0] MODE_QUAD   = 8'h01;
  localparam logic [7:0] DUM_L3_FAST = 8'h04;
  localparam logic [7:0] DUM_L3_DUAL = 8'h04;
  localparam logic [7:0] DUM_L3_QUAD = 8'h03;
  localparam logic [7:0] DUM_L0_FAST = 8'h05;
  localparam logic [7:0] DUM_L0_DUAL = 8'h06;
  localparam logic [7:0] DUM_L0_QUAD = 8'h06;
  localparam logic [7:0] DUM_L1_FAST = 8'h06;
  localparam logic [7:0] DUM_L1_DUAL = 8'h07;
  localparam logic [7:0] DUM_L1_QUAD = 8'h07;
  localparam logic [7:0] DUM_L2_FAST = 8'h07;
  localparam logic [7:0] DUM_L2_DUAL = 8'h08;
  localparam logic [7:0] DUM_L2_QUAD = 8'h08;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  // -----------------------------------------------------------------
  // read command kinds
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    DDRL_CMD_FAST = 2'h0,
    DDRL_CMD_DUAL = 2'h1,
    DDRL_CMD_QUAD = 2'h2
  } ddrl_cmd_t;
  // gap sequencer states, gray along idle-mode-dummy-data
  typedef enum logic [1:0] {
    DDRL_IDLE  = 2'b00,
    DDRL_MODE  = 2'b01,
    DDRL_DUMMY = 2'b11,
    DDRL_DATA  = 2'b10
  } ddrl_state_t;
endpackage
`default_nettype wire

/* ddrl_cnt_if.sv */
// ddrl_cnt_if: cycle counts passed from table to gap sequencer
// assumes: both ends on the same clock
`default_nettype none
interface ddrl_cnt_if;
  logic [7:0] mode_cnt;
  logic [7:0] dummy_cnt;
  modport table_end (output mode_cnt, output dummy_cnt);
  modport gap_end   (input mode_cnt, input dummy_cnt);
endinterface
`default_nettype wire

/* ddrl_gap.sv */
// ddrl_gap: times mode and dummy phases after the address phase
// assumes: counts stay stable for the whole read
`default_nettype none
module ddrl_gap (
  input  wire logic          clk_in,
  input  wire logic          reset_n_in,
  input  wire logic          clk_en_in,
  input  wire logic          addr_done_in,
  input  wire logic          read_end_in,
  ddrl_cnt_if.gap_end        cnt,
  output var  logic          mode_phase_out,
  output var  logic          dummy_phase_out,
  output var  logic          data_en_out
);
  ddrl_pkg::ddrl_state_t state_r;
  logic [7:0]            left_r;

  // -----------------------------------------------------------------
  // phase sequence
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ddrl_pkg::DDRL_IDLE;
      left_r  <= ddrl_pkg::BYTE_RESET;
    end else if (clk_en_in) begin
      case (state_r)
        ddrl_pkg::DDRL_IDLE: begin
          if (addr_done_in) begin
            // mode first, then dummy, then data
            if (cnt.mode_cnt != ddrl_pkg::MODE_NONE) begin
              state_r <= ddrl_pkg::DDRL_MODE;
              left_r  <= cnt.mode_cnt;
            end else if (cnt.dummy_cnt != ddrl_pkg::BYTE_RESET) begin
              state_r <= ddrl_pkg::DDRL_DUMMY;
              left_r  <= cnt.dummy_cnt;
            end else begin
              state_r <= ddrl_pkg::DDRL_DATA;
            end
          end
        end
        ddrl_pkg::DDRL_MODE: begin
          if (read_end_in) begin
            state_r <= ddrl_pkg::DDRL_IDLE;
          end else if (left_r == 8'h01) begin
            state_r <= (cnt.dummy_cnt != ddrl_pkg::BYTE_RESET) ?
                       ddrl_pkg::DDRL_DUMMY : ddrl_pkg::DDRL_DATA;
            left_r  <= cnt.dummy_cnt;
          end else begin
            left_r <= left_r - 8'h01;
          end
        end
        ddrl_pkg::DDRL_DUMMY: begin
          if (read_end_in) begin
            state_r <= ddrl_pkg::DDRL_IDLE;
          end else if (left_r == 8'h01) begin
            state_r <= ddrl_pkg::DDRL_DATA;
          end else begin
            left_r <= left_r - 8'h01;
          end
        end
        ddrl_pkg::DDRL_DATA: begin
          if (read_end_in) begin
            state_r <= ddrl_pkg::DDRL_IDLE;
          end
        end
        default: state_r <= ddrl_pkg::DDRL_IDLE;
      endcase
    end
  end

  assign mode_phase_out  = (state_r == ddrl_pkg::DDRL_MODE);
  assign dummy_phase_out = (state_r == ddrl_pkg::DDRL_DUMMY);
  assign data_en_out     = (state_r == ddrl_pkg::DDRL_DATA);

  // data never starts straight from the address phase when dummies exist
  a_data_after_dummy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(data_en_out) && cnt.dummy_cnt != 8'h00 |-> $past(dummy_phase_out))
    else $error("data started without dummy phase");
  a_mode_before_dummy: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(dummy_phase_out) && cnt.mode_cnt != 8'h00 |-> $past(mode_phase_out))
    else $error("dummy phase skipped mode cycles");
endmodule
`default_nettype wire

/* ddrl_table.sv */
// ddrl_table: ddr read latency lookup table with query byte port
// assumes: latency code and command stable during a read; addr_done marks end of address
//
// Notes on behaviour
// - code 00b: 66 MHz, dummies 5/6/6
// - code 01b: 66 MHz, dummies 6/7/7
// - code 10b: 66 MHz, dummies 7/8/8
// - row code 00b reports ceiling byte 42h
// - row code 01b reports ceiling byte 42h
// - one mode cycle for quad only
// - code 11b: 50 MHz, dummies 4/4/3
`default_nettype none
module ddrl_table (
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                clk_en_in,
  input  wire logic [1:0]          lat_code_in,
  input  wire ddrl_pkg::ddrl_cmd_t read_cmd_in,
  input  wire logic                addr_done_in,
  input  wire logic                read_end_in,
  input  wire logic [7:0]          query_addr_in,
  output var  logic [7:0]          query_data_out,
  output var  logic [7:0]          mode_cycles_out,
  output var  logic [7:0]          dummy_cycles_out,
  output var  logic [7:0]          freq_limit_out,
  output var  logic                mode_phase_out,
  output var  logic                dummy_phase_out,
  output var  logic                data_en_out
);
  // -----------------------------------------------------------------
  // row storage
  // -----------------------------------------------------------------
  logic [7:0] rows [ddrl_pkg::NUM_ROWS][8];
  logic [7:0] mode_cycles_nxt;
  logic [7:0] dummy_cycles_nxt;
  logic [7:0] freq_limit_nxt;
  logic [7:0] query_data_nxt;
  logic [7:0] rel;
  ddrl_cnt_if cnt_bus ();

  localparam logic [1:0]  ROW_CODES [ddrl_pkg::NUM_ROWS] = '{ddrl_pkg::CODE_ROW0,
    ddrl_pkg::CODE_ROW1, ddrl_pkg::CODE_ROW2, ddrl_pkg::CODE_ROW3};
  localparam logic [7:0]  ROW_FREQ [ddrl_pkg::NUM_ROWS] = '{ddrl_pkg::FREQ_50MHZ,
    ddrl_pkg::FREQ_66MHZ, ddrl_pkg::FREQ_66MHZ, ddrl_pkg::FREQ_66MHZ};
  localparam logic [7:0]  ROW_FAST [ddrl_pkg::NUM_ROWS] = '{ddrl_pkg::DUM_L3_FAST,
    ddrl_pkg::DUM_L0_FAST, ddrl_pkg::DUM_L1_FAST, ddrl_pkg::DUM_L2_FAST};
  localparam logic [7:0]  ROW_DUAL [ddrl_pkg::NUM_ROWS] = '{ddrl_pkg::DUM_L3_DUAL,
    ddrl_pkg::DUM_L0_DUAL, ddrl_pkg::DUM_L1_DUAL, ddrl_pkg::DUM_L2_DUAL};
  localparam logic [7:0]  ROW_QUAD [ddrl_pkg::NUM_ROWS] = '{ddrl_pkg::DUM_L3_QUAD,
    ddrl_pkg::DUM_L0_QUAD, ddrl_pkg::DUM_L1_QUAD, ddrl_pkg::DUM_L2_QUAD};

  // one row per latency code: freq, code, then mode/dummy pairs
  for (genvar g = 0; g < ddrl_pkg::NUM_ROWS; g++) begin : g_row
    assign rows[g][0] = ROW_FREQ[g];
    assign rows[g][1] = {6'h00, ROW_CODES[g]};
    assign rows[g][2] = ddrl_pkg::MODE_NONE;
    assign rows[g][3] = ROW_FAST[g];
    assign rows[g][4] = ddrl_pkg::MODE_NONE;
    assign rows[g][5] = ROW_DUAL[g];
    assign rows[g][6] = ddrl_pkg::MODE_QUAD;
    assign rows[g][7] = ROW_QUAD[g];
  end

  // -----------------------------------------------------------------
  // lookup by code and command
  // -----------------------------------------------------------------
  always_comb begin
    mode_cycles_nxt  = ddrl_pkg::MODE_NONE;
    dummy_cycles_nxt = ddrl_pkg::BYTE_RESET;
    freq_limit_nxt   = ddrl_pkg::BYTE_RESET;
    for (int i = 0; i < ddrl_pkg::NUM_ROWS; i++) begin
      if (ROW_CODES[i] == lat_code_in) begin
        freq_limit_nxt = rows[i][0];
        case (read_cmd_in)
          ddrl_pkg::DDRL_CMD_FAST: begin
            mode_cycles_nxt  = rows[i][2];
            dummy_cycles_nxt = rows[i][3];
          end
          ddrl_pkg::DDRL_CMD_DUAL: begin
            mode_cycles_nxt  = rows[i][4];
            dummy_cycles_nxt = rows[i][5];
          end
          default: begin
            mode_cycles_nxt  = rows[i][6];
            dummy_cycles_nxt = rows[i][7];
          end
        endcase
      end
    end
  end

  // query bytes: offsets 0ch..2bh, other offsets read zero
  always_comb begin
    rel            = query_addr_in - ddrl_pkg::ROW_BASE;
    query_data_nxt = ddrl_pkg::BYTE_RESET;
    if (query_addr_in >= ddrl_pkg::ROW_BASE && query_addr_in <= ddrl_pkg::OFS_LAST) begin
      query_data_nxt = rows[rel[4:3]][rel[2:0]];
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_cycles_out  <= ddrl_pkg::BYTE_RESET;
      dummy_cycles_out <= ddrl_pkg::BYTE_RESET;
      freq_limit_out   <= ddrl_pkg::BYTE_RESET;
    end else if (clk_en_in) begin
      mode_cycles_out  <= mode_cycles_nxt;
      dummy_cycles_out <= dummy_cycles_nxt;
      freq_limit_out   <= freq_limit_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      query_data_out <= ddrl_pkg::BYTE_RESET;
    end else if (clk_en_in) begin
      query_data_out <= query_data_nxt;
    end
  end

  // -----------------------------------------------------------------
  // gap sequencer
  // -----------------------------------------------------------------
  assign cnt_bus.mode_cnt  = mode_cycles_out;
  assign cnt_bus.dummy_cnt = dummy_cycles_out;

  ddrl_gap u_gap (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .clk_en_in       (clk_en_in),
    .addr_done_in    (addr_done_in),
    .read_end_in     (read_end_in),
    .cnt             (cnt_bus),
    .mode_phase_out  (mode_phase_out),
    .dummy_phase_out (dummy_phase_out),
    .data_en_out     (data_en_out)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_code0_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && lat_code_in == 2'h0 |=> freq_limit_out == 8'h42 &&
    dummy_cycles_out == (($past(read_cmd_in) == ddrl_pkg::DDRL_CMD_FAST) ? 8'h05 : 8'h06))
    else $error("code 00b row wrong");
  a_code1_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && lat_code_in == 2'h1 |=> freq_limit_out == 8'h42 &&
    dummy_cycles_out == (($past(read_cmd_in) == ddrl_pkg::DDRL_CMD_FAST) ? 8'h06 : 8'h07))
    else $error("code 01b row wrong");
  a_code2_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && lat_code_in == 2'h2 |=> freq_limit_out == 8'h42 &&
    dummy_cycles_out == (($past(read_cmd_in) == ddrl_pkg::DDRL_CMD_FAST) ? 8'h07 : 8'h08))
    else $error("code 10b row wrong");
  a_code3_counts: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && lat_code_in == 2'h3 |=> freq_limit_out == 8'h32 &&
    dummy_cycles_out == (($past(read_cmd_in) < ddrl_pkg::DDRL_CMD_QUAD) ? 8'h04 : 8'h03))
    else $error("code 11b row wrong");
  a_row_freq0: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h14 |=> query_data_out == 8'h42)
    else $error("code 00b ceiling byte wrong");
  a_row_freq1: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h1c |=> query_data_out == 8'h42)
    else $error("code 01b ceiling byte wrong");
  a_mode_quad: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in |=> mode_cycles_out == (($past(read_cmd_in) < ddrl_pkg::DDRL_CMD_QUAD) ?
    8'h00 : 8'h01))
    else $error("mode cycle count wrong");
  a_dummy_length: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(dummy_phase_out) && dummy_cycles_out == 8'h05 && clk_en_in && !read_end_in
    ##1 (clk_en_in && !read_end_in)[*4] |=> data_en_out)
    else $error("data not after five dummies");

  // -----------------------------------------------------------------
  // query byte checks
  // -----------------------------------------------------------------
  a_c0_fast_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h17 |=> query_data_out == 8'h05)
    else $error("code 00b fast dummy byte wrong");
  a_c0_dual_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h19 |=> query_data_out == 8'h06)
    else $error("code 00b dual dummy byte wrong");
  a_c0_quad_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h1b |=> query_data_out == 8'h06)
    else $error("code 00b quad dummy byte wrong");
  a_c1_fast_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h1f |=> query_data_out == 8'h06)
    else $error("code 01b fast dummy byte wrong");
  a_c1_dual_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h21 |=> query_data_out == 8'h07)
    else $error("code 01b dual dummy byte wrong");
  a_c1_quad_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h23 |=> query_data_out == 8'h07)
    else $error("code 01b quad dummy byte wrong");
  a_c2_fast_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h27 |=> query_data_out == 8'h07)
    else $error("code 10b fast dummy byte wrong");
  a_c2_dual_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h29 |=> query_data_out == 8'h08)
    else $error("code 10b dual dummy byte wrong");
  a_c2_quad_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h2b |=> query_data_out == 8'h08)
    else $error("code 10b quad dummy byte wrong");
  a_c3_freq_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h0c |=> query_data_out == 8'h32)
    else $error("code 11b ceiling byte wrong");
  a_c3_fast_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h0f |=> query_data_out == 8'h04)
    else $error("code 11b fast dummy byte wrong");
  a_c3_dual_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h11 |=> query_data_out == 8'h04)
    else $error("code 11b dual dummy byte wrong");
  a_c3_quad_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in == 8'h13 |=> query_data_out == 8'h03)
    else $error("code 11b quad dummy byte wrong");
  a_quad_mode_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in inside {8'h12, 8'h1a, 8'h22, 8'h2a} |=> query_data_out == 8'h01)
    else $error("quad mode byte wrong");
  a_no_mode_byte: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    clk_en_in && query_addr_in inside {8'h0e, 8'h10, 8'h16, 8'h18, 8'h1e, 8'h20, 8'h26,
    8'h28} |=> query_data_out == 8'h00)
    else $error("fast or dual mode byte wrong");
endmodule
`default_nettype wire

/* ddrl_host_model.sv */
// ddrl_host_model: query-side host that reads table bytes
// assumes: bench calls query only after reset is released
`default_nettype none
module ddrl_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] data_in,
  output var  logic       clk_en_out,
  output var  logic [7:0] addr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    clk_en_out = 1'b1;
    addr_out   = 8'h00;
  end
  // a slow host freezes the device with the new offset already applied
  task automatic query(input logic [7:0] a, input int stall,
                       output logic [7:0] d, output logic [7:0] h);
    @(posedge clk_in);
    #1;
    addr_out = a;
    if (stall > 0) begin
      clk_en_out = 1'b0;
      repeat (stall) @(posedge clk_in);
      #1;
      clk_en_out = 1'b1;
    end
    h = data_in;
    @(posedge clk_in);
    #1;
    d = data_in;
    // offset released: show its inverse, not the last value
    addr_out = ~a;
  endtask
endmodule
`default_nettype wire

/* ddrl_table_tb.sv */
// ddrl_table_tb: self-checking bench for the ddr latency table
// assumes: ddrl_table on one 10 MHz clock, host model on the query side
`default_nettype none
module ddrl_table_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                clk_in     = 1'b0;
  logic                reset_n_in = 1'b0;
  logic [1:0]          lat_code   = 2'h0;
  ddrl_pkg::ddrl_cmd_t read_cmd   = ddrl_pkg::DDRL_CMD_FAST;
  logic                addr_done  = 1'b0;
  logic                read_end   = 1'b0;
  logic                clk_en;
  logic [7:0]          q_addr, q_data, mode_c, dum_c, freq;
  logic                mode_ph, dum_ph, data_en;
  int                  errors     = 0;
  int                  n_checks   = 0;
  // per code: ceiling, fast, dual, quad dummies
  logic [7:0]          ref_row [4][4];
  // ------------------------------------------------------------
  // clock, units
  // ------------------------------------------------------------
  always #50 clk_in = ~clk_in; // 10 MHz, under every ceiling
  ddrl_table u_ddrl_table (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .lat_code_in(lat_code), .read_cmd_in(read_cmd), .addr_done_in(addr_done),
    .read_end_in(read_end), .query_addr_in(q_addr), .query_data_out(q_data),
    .mode_cycles_out(mode_c), .dummy_cycles_out(dum_c), .freq_limit_out(freq),
    .mode_phase_out(mode_ph), .dummy_phase_out(dum_ph), .data_en_out(data_en)
  );
  ddrl_host_model u_ddrl_host_model (
    .clk_in(clk_in), .data_in(q_data), .clk_en_out(clk_en), .addr_out(q_addr)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_byte(input int a);
    int c;
    if (a < 12 || a > 43) return 8'h00;
    c = ((a - 12) / 8 + 3) % 4;
    case ((a - 12) % 8)
      0: return ref_row[c][0];
      1: return 8'(c);
      3: return ref_row[c][1];
      5: return ref_row[c][2];
      6: return 8'h01;
      7: return ref_row[c][3];
      default: return 8'h00;
    endcase
  endfunction
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    repeat (16) @(posedge clk_in);
    #1;
    chk(q_data | mode_c | dum_c | freq, 8'h00);
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
    reset_n_in = 1'b1;
    repeat (2) tick();
    $display("test reset done");
  endtask
  task automatic t_query;
    logic [7:0] d, h;
    for (int a = 11; a <= 44; a++) begin
      u_ddrl_host_model.query(8'(a), a % 3, d, h);
      chk(d, exp_byte(a));
      chk(h, 8'h00);
    end
    $display("test query done");
  endtask
  task automatic t_gap;
    int m, n, q;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        // command code 3 decodes as quad
        q = (k == 3) ? 3 : k + 1;
        lat_code = 2'(c);
        read_cmd = ddrl_pkg::ddrl_cmd_t'(k);
        repeat (2) tick();
        chk(freq, ref_row[c][0]);
        chk(dum_c, ref_row[c][q]);
        chk(mode_c, (k >= 2) ? 8'h01 : 8'h00);
        addr_done = 1'b1;
        tick();
        addr_done = 1'b0;
        m = 0;
        n = 0;
        while (mode_ph === 1'b1 && m < 20) begin
          m++;
          tick();
        end
        while (dum_ph === 1'b1 && data_en === 1'b0 && n < 20) begin
          n++;
          tick();
        end
        chk(8'(m), (k >= 2) ? 8'h01 : 8'h00);
        chk(8'(n), ref_row[c][q]);
        chk({7'h0, data_en}, 8'h01);
        read_end = 1'b1;
        tick();
        read_end = 1'b0;
        chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
      end
    end
    $display("test gap done");
  endtask
  task automatic t_abort;
    lat_code = 2'h2;
    read_cmd = ddrl_pkg::DDRL_CMD_QUAD;
    repeat (2) tick();
    addr_done = 1'b1;
    tick();
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h04);
    tick();
    addr_done = 1'b0;
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h02);
    tick();
    read_end = 1'b1;
    tick();
    read_end = 1'b0;
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
    repeat (10) tick();
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
    // reset in mid-read, then the lookups reload
    addr_done = 1'b1;
    tick();
    addr_done = 1'b0;
    tick();
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h02);
    reset_n_in = 1'b0;
    tick();
    chk(q_data | mode_c | dum_c | freq, 8'h00);
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
    reset_n_in = 1'b1;
    repeat (2) tick();
    chk(freq, 8'h42);
    chk(dum_c, 8'h08);
    chk(mode_c, 8'h01);
    chk({5'h0, mode_ph, dum_ph, data_en}, 8'h00);
    $display("test abort done");
  endtask
  initial begin
    ref_row[0] = '{8'h42, 8'h05, 8'h06, 8'h06};
    ref_row[1] = '{8'h42, 8'h06, 8'h07, 8'h07};
    ref_row[2] = '{8'h42, 8'h07, 8'h08, 8'h08};
    ref_row[3] = '{8'h32, 8'h04, 8'h04, 8'h03};
    t_reset();
    t_query();
    t_gap();
    t_abort();
    close_out();
  end
  initial begin
    #(3000 * 100);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
